// ---- logic/its_pkg.sv ----
package its_pkg;
	localparam int unsigned AW = 6;
	localparam logic [AW-1:0] OFS_CFG = 6'h00;
	localparam logic [AW-1:0] OFS_VAB = 6'h04;
	localparam logic [AW-1:0] OFS_CPS = 6'h08;
	localparam logic [AW-1:0] OFS_OPS = 6'h0c;
	localparam logic [AW-1:0] OFS_CHC = 6'h10;
	localparam logic [AW-1:0] OFS_PC0 = 6'h14;
	localparam logic [AW-1:0] OFS_PC1 = 6'h18;
	localparam logic [AW-1:0] OFS_PC2 = 6'h1c;
	localparam logic [AW-1:0] OFS_STA = 6'h20;
	localparam int unsigned CFG_VF = 0;
	localparam int unsigned CFG_RV = 1;
	localparam int unsigned CPS_DA = 0;
	localparam int unsigned CPS_DI = 1;
	localparam int unsigned CPS_IM = 2;
	localparam int unsigned CPS_RE = 4;
	localparam int unsigned CPS_IP = 5;
	localparam int unsigned CPS_FZ = 10;
	localparam logic [31:0] CPS_RST = 32'h0000_0001;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CPS_POST_VAL = 32'h0000_0401;
	localparam logic [31:0] CPS_POST_MSK = 32'h0000_0c23;
	localparam int unsigned VEC_R_BIT = 0;
	localparam int unsigned VEA_LSB = 2;
	localparam int unsigned VDA_LSB = 8;
	localparam logic [7:0] VEC_FP_BASE = 8'h2e;
	localparam logic [7:0] VEC_RSV_LO = 8'h38;
	localparam logic [7:0] VEC_INST_LO = 8'h40;
	localparam int unsigned STA_VEC = 8;
	localparam int unsigned STA_RSV = 16;
	localparam logic [2:0] FP_LT = 3'h0;
	localparam logic [2:0] FP_ADD = 3'h1;
	localparam logic [2:0] FP_SUB = 3'h2;
	localparam logic [2:0] FP_MUL = 3'h3;
	localparam logic [2:0] FP_DIV = 3'h4;
	typedef enum logic [1:0] {
		ITS_SRC_FIXED = 2'h0,
		ITS_SRC_FP    = 2'h1,
		ITS_SRC_INST  = 2'h2
	} its_src_e;
	typedef struct packed {
		its_src_e   src;
		logic [7:0] num;
		logic [2:0] fp_op;
		logic       fp_dbl;
	} its_trap_s;
	typedef struct packed {
		logic multiple_op;
		logic not_needed;
		logic contents_valid;
	} its_chc_s;
	typedef enum logic [16:0] {
		S_IDLE  = 17'h00001,
		S_STOPX = 17'h00002,
		S_STOPF = 17'h00004,
		S_DRAIN = 17'h00008,
		S_SAVE  = 17'h00010,
		S_LOAD  = 17'h00020,
		S_VREQ  = 17'h00040,
		S_VWAIT = 17'h00080,
		S_GO    = 17'h00100,
		S_RWAIT = 17'h00200,
		S_RINV  = 17'h00400,
		S_RREST = 17'h00800,
		S_RCHAN = 17'h01000,
		S_RF1   = 17'h02000,
		S_RF0   = 17'h04000,
		S_RML   = 17'h08000,
		S_RDONE = 17'h10000
	} its_state_e;
endpackage

// ---- logic/its_vec_map.sv ----
`timescale 1ns/10ps
`default_nettype none
module its_vec_map
	import its_pkg::*;
(
	input  wire its_trap_s   trap,
	input  wire logic [31:0] base,
	output logic [7:0]       vec_num,
	output logic             vec_rsv,
	output logic [31:0]      entry_addr,
	output logic [31:0]      direct_addr
);
	logic [7:0] fp_num;

	// single and double alternate, one pair per operation
	assign fp_num = VEC_FP_BASE + {4'h0, trap.fp_op, trap.fp_dbl}; // RULE2

	always_comb begin
		case (trap.src)
			ITS_SRC_FP:   vec_num = fp_num; // RULE2
			ITS_SRC_INST: vec_num = trap.num; // RULE1
			default:      vec_num = trap.num;
		endcase
	end

	// reserved numbers are still taken, but flagged for software
	assign vec_rsv = (vec_num >= VEC_RSV_LO) && (vec_num < VEC_INST_LO); // RULE1

	always_comb begin
		entry_addr = base; // RULE22
		entry_addr[VEA_LSB +: 8] = vec_num;
		direct_addr = base;
		direct_addr[VDA_LSB +: 8] = vec_num;
	end
endmodule // its_vec_map
`default_nettype wire

// ---- logic/its_psr.sv ----
`timescale 1ns/10ps
`default_nettype none
module its_psr
	import its_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        sw_cps,
	input  wire logic        sw_ops,
	input  wire logic [31:0] wdata,
	input  wire logic        save,
	input  wire logic        post,
	input  wire logic        set_re,
	input  wire logic        re_val,
	input  wire logic        restore,
	output logic [31:0]      cps,
	output logic [31:0]      ops
);
	always_ff @(posedge clock) begin
		if (reset) begin
			cps <= CPS_RST;
		end else if (post) begin
			cps <= (cps & ~CPS_POST_MSK) | (CPS_POST_VAL & CPS_POST_MSK); // RULE23
		end else if (set_re) begin
			cps[CPS_RE] <= re_val; // RULE8
		end else if (restore) begin
			cps <= ops; // RULE14
		end else if (sw_cps) begin
			cps <= wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ops <= CPS_RST;
		end else if (save) begin
			ops <= cps; // RULE5
		end else if (sw_ops) begin
			ops <= wdata;
		end
	end
endmodule // its_psr
`default_nettype wire

// ---- logic/its_seq.sv ----
// Summary of operation
// [RULE1] vectors 56-63 reserved; 64-255 come from the trapping instruction
// [RULE2] fp compare/add/sub/mul/div traps use 46-55, single and double alternating
// [RULE3] on a trap stop execution first, then fetch, before status changes
// [RULE4] let a running load or store finish; cancel rest of a multiple
// [RULE5] copy current status to old status, then load post-trap status
// [RULE6] freeze blocks channel, program counter and alu status updates
// [RULE7] vector_fetch set reads a vector; clear forms address directly
// [RULE8] rom_enable from vector flag when fetching, else from rom_vectors
// [RULE9] fetch at the handler address and resume normal execution
// [RULE10] nothing but the status word is saved automatically
// [RULE11] flushing return clears all branch cache valid bits; plain return does not
// [RULE12] return waits for pending load/store and any multiple sequence
// [RULE13] no interrupt or trap accepted from cache flush to multiple restart
// [RULE14] return copies old status into current status, normally clearing freeze
// [RULE15] valid, needed, single channel access restarts after status restore
// [RULE16] first return fetch from counter 1 as branch, goes to decode
// [RULE17] second fetch from counter 0 as branch; pipeline advances
// [RULE18] valid, needed, multiple channel operation restarts after both fetches
// [RULE19] return ends by re-enabling interrupts per restored status
// [RULE20] software prepares freeze, old status, channel and counters before return
// [RULE21] live status bits such as pending ignore the restored value
// [RULE22] vector entry replaces base bits 9-2; direct address replaces bits 15-8
// [RULE23] post-trap status is one parameterised constant pattern with freeze set
`timescale 1ns/10ps
`default_nettype none
module its_seq
	import its_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        trap_req,
	input  wire its_trap_s   trap_info,
	output logic             trap_ack,
	input  wire logic        ret_req,
	input  wire logic        ret_flush,
	output logic             ret_ack,
	input  wire logic        ls_busy,
	input  wire logic        lm_active,
	input  wire logic        irq_pending,
	input  wire logic        pc_step,
	input  wire logic [31:0] pc_next,
	input  wire logic        chc_we,
	input  wire its_chc_s    chc_next,
	output logic             exec_hold,
	output logic             fetch_hold,
	output logic             lm_cancel,
	output logic             vmem_read,
	output logic [31:0]      vmem_address,
	input  wire logic        vmem_valid,
	input  wire logic [31:0] vmem_readdata,
	output logic             fetch_go,
	output logic             fetch_branch,
	output logic [31:0]      fetch_addr,
	output logic             to_decode,
	output logic             to_execute,
	output logic             btc_flush,
	output logic             chan_restart,
	output logic             lm_restart,
	output logic             irq_block,
	output logic             freeze
);
	its_state_e  state;
	its_state_e  next_state;
	logic [31:0] cfg;
	logic [31:0] vab;
	its_chc_s    chc;
	logic [31:0] pc0;
	logic [31:0] pc1;
	logic [31:0] pc2;
	its_trap_s   trap_q;
	logic [31:0] handler;
	logic        flush_q;
	logic        vrsv_q;
	logic [7:0]  vnum_q;
	logic [31:0] cps;
	logic [31:0] ops;
	logic [31:0] cps_view;
	logic [7:0]  vec_num;
	logic        vec_rsv;
	logic [31:0] entry_addr;
	logic [31:0] direct_addr;
	logic        wr_ok;
	logic        frz;
	logic        chan_one;
	logic        chan_many;

	assign wr_ok = write && !waitrequest;
	assign frz = cps[CPS_FZ];
	assign chan_one = chc.contents_valid && !chc.not_needed && !chc.multiple_op;
	assign chan_many = chc.contents_valid && !chc.not_needed && chc.multiple_op;

	its_vec_map u_map (
		.trap        (trap_q),
		.base        (vab),
		.vec_num     (vec_num),
		.vec_rsv     (vec_rsv),
		.entry_addr  (entry_addr),
		.direct_addr (direct_addr)
	);

	its_psr u_psr (
		.clock   (clock),
		.reset   (reset),
		.sw_cps  (wr_ok && address == OFS_CPS),
		.sw_ops  (wr_ok && address == OFS_OPS),
		.wdata   (writedata),
		.save    (state == S_SAVE), // RULE10
		.post    (state == S_LOAD),
		.set_re  (state == S_GO),
		.re_val  (cfg[CFG_VF] ? handler[VEC_R_BIT] : cfg[CFG_RV]),
		.restore (state == S_RREST),
		.cps     (cps),
		.ops     (ops)
	);

	// sequencer: a new request is looked at only in idle, which keeps traps out
	// for the whole return
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (trap_req) begin
					next_state = S_STOPX;
				end else if (ret_req) begin
					next_state = S_RWAIT;
				end
			end
			S_STOPX: next_state = S_STOPF; // RULE3
			S_STOPF: next_state = S_DRAIN; // RULE3
			S_DRAIN: begin
				if (!ls_busy) begin
					next_state = S_SAVE; // RULE4
				end
			end
			S_SAVE:  next_state = S_LOAD; // RULE5
			S_LOAD:  next_state = cfg[CFG_VF] ? S_VREQ : S_GO; // RULE7
			S_VREQ:  next_state = S_VWAIT;
			S_VWAIT: begin
				if (vmem_valid) begin
					next_state = S_GO;
				end
			end
			S_GO:    next_state = S_IDLE; // RULE9
			S_RWAIT: begin
				if (!ls_busy && !lm_active) begin
					next_state = S_RINV; // RULE12
				end
			end
			S_RINV:  next_state = S_RREST;
			S_RREST: next_state = S_RCHAN;
			S_RCHAN: next_state = S_RF1;
			S_RF1:   next_state = S_RF0;
			S_RF0:   next_state = S_RML;
			S_RML:   next_state = S_RDONE;
			S_RDONE: next_state = S_IDLE; // RULE19
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// trap source and return kind are caught at acceptance
	always_ff @(posedge clock) begin
		if (reset) begin
			trap_q <= '0;
			flush_q <= 1'b0;
		end else if (state == S_IDLE) begin
			trap_q <= trap_info;
			flush_q <= ret_flush;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			vnum_q <= 8'h00;
			vrsv_q <= 1'b0;
		end else if (state == S_LOAD) begin
			vnum_q <= vec_num;
			vrsv_q <= vec_rsv; // RULE1
		end
	end

	// handler address, direct or fetched; the low bits of a fetched word carry
	// the rom flag, so they are kept until the status takes it
	always_ff @(posedge clock) begin
		if (reset) begin
			handler <= '0;
		end else if (state == S_LOAD && !cfg[CFG_VF]) begin
			handler <= direct_addr; // RULE7
		end else if (state == S_VWAIT && vmem_valid) begin
			handler <= vmem_readdata; // RULE8
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			trap_ack <= 1'b0;
			ret_ack <= 1'b0;
		end else begin
			trap_ack <= state == S_IDLE && trap_req;
			ret_ack <= state == S_IDLE && !trap_req && ret_req;
		end
	end

	// hold flags stay up from the stop steps until the new stream starts
	always_ff @(posedge clock) begin
		if (reset) begin
			exec_hold <= 1'b0;
			fetch_hold <= 1'b0;
		end else begin
			exec_hold <= next_state != S_IDLE; // RULE3
			fetch_hold <= next_state != S_IDLE && next_state != S_STOPX; // RULE3
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			lm_cancel <= 1'b0;
		end else begin
			lm_cancel <= next_state == S_DRAIN; // RULE4
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			vmem_read <= 1'b0;
			vmem_address <= '0;
		end else begin
			vmem_read <= next_state == S_VWAIT; // RULE7
			if (next_state == S_VWAIT) begin
				vmem_address <= entry_addr; // RULE22
			end
		end
	end

	// fetch port: handler fetch, then the two return fetches as branches
	always_ff @(posedge clock) begin
		if (reset) begin
			fetch_go <= 1'b0;
			fetch_branch <= 1'b0;
			fetch_addr <= '0;
		end else begin
			fetch_go <= 1'b0;
			fetch_branch <= 1'b0;
			if (state == S_GO) begin
				fetch_go <= 1'b1; // RULE9
				fetch_addr <= {handler[31:2], 2'h0};
			end else if (state == S_RF1) begin
				fetch_go <= 1'b1; // RULE16
				fetch_branch <= 1'b1;
				fetch_addr <= pc1;
			end else if (state == S_RF0) begin
				fetch_go <= 1'b1; // RULE17
				fetch_branch <= 1'b1;
				fetch_addr <= pc0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			to_decode <= 1'b0;
			to_execute <= 1'b0;
		end else begin
			to_decode <= state == S_RF1 || state == S_RF0; // RULE16
			to_execute <= state == S_RF0; // RULE17
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			btc_flush <= 1'b0;
		end else begin
			btc_flush <= state == S_RINV && flush_q; // RULE11
		end
	end

	// channel restart sees the status restored one step earlier; multiple restart follows both fetches
	always_ff @(posedge clock) begin
		if (reset) begin
			chan_restart <= 1'b0;
			lm_restart <= 1'b0;
		end else begin
			chan_restart <= state == S_RCHAN && chan_one; // RULE15
			lm_restart <= state == S_RML && chan_many; // RULE18
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_block <= 1'b0;
		end else begin
			irq_block <= next_state inside {S_RINV, S_RREST, S_RCHAN, S_RF1, S_RF0, S_RML,
				S_RDONE}; // RULE13
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			freeze <= 1'b0;
		end else begin
			freeze <= frz; // RULE6
		end
	end

	// counters shift on a sequential step only while not frozen; software
	// writes stay open so a handler can prepare a return
	always_ff @(posedge clock) begin
		if (reset) begin
			pc0 <= '0;
			pc1 <= '0;
			pc2 <= '0;
		end else if (wr_ok && address == OFS_PC0) begin
			pc0 <= writedata; // RULE20
		end else if (wr_ok && address == OFS_PC1) begin
			pc1 <= writedata; // RULE20
		end else if (wr_ok && address == OFS_PC2) begin
			pc2 <= writedata;
		end else if (pc_step && !frz) begin
			pc2 <= pc1; // RULE6
			pc1 <= pc0;
			pc0 <= pc_next;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			chc <= '0;
		end else if (wr_ok && address == OFS_CHC) begin
			chc <= writedata[2:0]; // RULE20
		end else if (chc_we && !frz) begin
			chc <= chc_next; // RULE6
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cfg <= CFG_RST;
			vab <= '0;
		end else if (wr_ok && address == OFS_CFG) begin
			cfg <= writedata;
		end else if (wr_ok && address == OFS_VAB) begin
			vab <= writedata;
		end
	end

	// pending bit always shows the live line, whatever was restored
	always_comb begin
		cps_view = cps;
		cps_view[CPS_IP] = irq_pending; // RULE21
	end

	// one wait cycle per access: answer on the second edge of a request
	always_ff @(posedge clock) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			readdata <= '0;
		end else if (address == OFS_CFG) begin
			readdata <= cfg;
		end else if (address == OFS_VAB) begin
			readdata <= vab;
		end else if (address == OFS_CPS) begin
			readdata <= cps_view;
		end else if (address == OFS_OPS) begin
			readdata <= ops;
		end else if (address == OFS_CHC) begin
			readdata <= {29'h0, chc};
		end else if (address == OFS_PC0) begin
			readdata <= pc0;
		end else if (address == OFS_PC1) begin
			readdata <= pc1;
		end else if (address == OFS_PC2) begin
			readdata <= pc2;
		end else if (address == OFS_STA) begin
			readdata <= {15'h0, vrsv_q, vnum_q, 7'h0, state != S_IDLE};
		end else begin
			readdata <= '0;
		end
	end
endmodule // its_seq
`default_nettype wire

// ---- tb/its_seq_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module its_seq_properties
	import its_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        trap_ack,
	input wire logic        ls_busy,
	input wire logic        exec_hold,
	input wire logic        fetch_hold,
	input wire logic        lm_cancel,
	input wire logic        vmem_read,
	input wire logic [31:0] vmem_address,
	input wire logic        vmem_valid,
	input wire logic        fetch_go,
	input wire logic        fetch_branch,
	input wire logic        to_decode,
	input wire logic        to_execute,
	input wire logic        btc_flush,
	input wire logic        chan_restart,
	input wire logic        lm_restart,
	input wire logic        irq_block
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	sequence s_halt;
		exec_hold && !fetch_hold ##1 exec_hold && fetch_hold;
	endsequence
	sequence s_refill;
		fetch_go && fetch_branch && to_decode && !to_execute
		##1 fetch_go && fetch_branch && to_decode && to_execute;
	endsequence
	stop_order_a: assert property (trap_ack |-> s_halt)
		else $error("fetch did not stop one cycle after execution");
	drain_wait_a: assert property (lm_cancel && ls_busy |=> lm_cancel)
		else $error("drain ended while a load or store was busy");
	vec_hold_a: assert property (vmem_read && !vmem_valid |=> vmem_read && $stable(vmem_address))
		else $error("vector read dropped or moved before its answer");
	handler_free_a: assert property (fetch_go && !irq_block |=> !exec_hold && !fetch_hold)
		else $error("holds stayed after the handler fetch");
	flush_inside_a: assert property (btc_flush |-> $past(irq_block) && irq_block)
		else $error("branch cache flush outside the blocked return");
	restart_block_a: assert property (chan_restart || lm_restart |-> irq_block)
		else $error("channel restart while interrupts were open");
	chan_first_a: assert property (chan_restart |-> ##[1:3] (fetch_go && !to_execute))
		else $error("first return fetch did not follow the channel restart");
	ret_refill_a: assert property (irq_block && fetch_go && !to_execute |-> s_refill)
		else $error("return refill order wrong");
	lm_after_a: assert property (lm_restart |-> $past(to_execute) && $past(fetch_go))
		else $error("multiple restart not right after the second fetch");
	unblock_end_a: assert property (irq_block && to_execute |-> ##[1:3] !irq_block)
		else $error("interrupts not reopened after the return");
endmodule // its_seq_properties
`default_nettype wire

// ---- tb/its_vmem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module its_vmem_model
	import its_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [3:0]  delay,
	input  wire logic        vmem_read,
	input  wire logic [31:0] vmem_address,
	output logic             vmem_valid,
	output logic [31:0]      vmem_readdata
);
	logic [3:0] wait_cnt;
	// data toggles between answers so a sample an odd number of cycles late never looks like a vector
	always_ff @(posedge clock) begin
		vmem_valid <= 1'h0;
		vmem_readdata <= ~vmem_readdata;
		if (reset) begin
			wait_cnt <= 4'h0;
			vmem_readdata <= 32'h0;
		end else if (vmem_read && !vmem_valid) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == delay) begin
				wait_cnt <= 4'h0;
				vmem_valid <= 1'h1;
				vmem_readdata <= {12'h4a0, vmem_address[9:2], 11'h0, vmem_address[2]};
			end
		end
	end
endmodule // its_vmem_model
`default_nettype wire

// ---- tb/its_seq_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module its_seq_bench
	import its_pkg::*;
;
	logic        clock = 1'h0, reset = 1'h1, read = 1'h0, write = 1'h0;
	logic        trap_req = 1'h0, ret_req = 1'h0, ret_flush = 1'h0, ls_busy = 1'h0;
	logic        lm_active = 1'h0, irq_pending = 1'h0, pc_step = 1'h0, chc_we = 1'h0;
	logic [5:0]  address = 6'h0;
	logic [31:0] writedata = 32'h0, pc_next = 32'h0;
	its_trap_s   trap_info = '0;
	its_chc_s    chc_next = '0;
	logic [3:0]  delay = 4'h0;
	logic [31:0] readdata, vmem_address, vmem_readdata, fetch_addr;
	logic        waitrequest, trap_ack, ret_ack, exec_hold, fetch_hold, lm_cancel;
	logic        vmem_read, vmem_valid, fetch_go, fetch_branch, to_decode, to_execute;
	logic        btc_flush, chan_restart, lm_restart, irq_block, freeze, rv, re;
	logic [3:0]  ev;
	logic [7:0]  vec;
	logic [31:0] fq[$], rq[$], vab, cps_exp, prior, r, h, p1, tgt;
	its_trap_s   t;
	int          failures = 0, checked = 0, seed = 10553, nf = 0, nc = 0, nl = 0;
	assign ev = {to_execute, ret_ack, fetch_go, trap_ack};
	always #4 clock = ~clock;
	its_seq dut (.*);
	its_vmem_model mem (.*);
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [31:0] vword(input logic [31:0] a);
		return {12'h4a0, a[9:2], 11'h0, a[2]};
	endfunction
	task automatic waitfor(input int k);
		int cnt;
		cnt = 0;
		do begin
			@(posedge clock);
			cnt++;
		end while (ev[k] !== 1'h1 && cnt < 100);
		if (cnt == 100) failures++;
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'h0);
		read <= 1'h0;
		write <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic trap(input its_trap_s ti, input logic [31:0] e);
		fq.push_back(e);
		@(posedge clock);
		trap_info <= ti;
		trap_req <= 1'h1;
		ls_busy <= e[3];
		waitfor(0);
		trap_req <= 1'h0;
		repeat (4) @(posedge clock);
		ls_busy <= 1'h0;
		waitfor(1);
	endtask
	task automatic ret(input logic fl, input logic busy);
		@(posedge clock);
		ret_req <= 1'h1;
		ret_flush <= fl;
		lm_active <= busy;
		ls_busy <= busy;
		waitfor(2);
		ret_req <= 1'h0;
		if (busy) repeat (4) begin
			@(posedge clock);
			check("irq_block", {31'h0, irq_block}, 32'h0);
		end
		lm_active <= 1'h0;
		ls_busy <= 1'h0;
		waitfor(3);
		repeat (4) @(posedge clock);
	endtask
	always @(posedge clock) begin
		if (read && !waitrequest) check("readdata", readdata, rq.pop_front());
		if (fetch_go === 1'h1) check("fetch_addr", fetch_addr, fq.pop_front());
		if (btc_flush === 1'h1) nf++;
		if (chan_restart === 1'h1) nc++;
		if (lm_restart === 1'h1) nl++;
	end
	initial begin
		repeat (40000) @(posedge clock);
		failures++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		rd(OFS_CPS, CPS_RST);
		rd(OFS_CFG, CFG_RST);
		bus(1'h1, 6'h3c, 32'hffff_ffff);
		rd(6'h3c, 32'h0);
		irq_pending <= 1'h1;
		rd(OFS_CPS, CPS_RST | 32'h20);
		irq_pending <= 1'h0;
		$display("test registers done");
		vab = $random(seed);
		bus(1'h1, OFS_VAB, vab);
		cps_exp = CPS_RST;
		for (int m = 0; m < 2; m++) begin
			r = $random(seed);
			rv = r[8];
			delay <= r[3:0];
			bus(1'h1, OFS_CFG, {30'h0, rv, m[0]});
			for (int i = 0; i < 14; i++) begin
				r = $random(seed);
				vec = (i < 10) ? 8'h2e + 8'(i) : (i == 10) ? 8'(r[15:0] % 46) :
					(i == 11) ? 8'h40 + 8'(r[15:0] % 192) :
					(i == 12) ? 8'h38 + {5'h0, r[2:0]} : 8'hff;
				t = '0;
				t.src = (i < 10) ? ITS_SRC_FP : (i[0] ? ITS_SRC_INST : ITS_SRC_FIXED);
				t.num = (i < 10) ? 8'h0 : vec;
				t.fp_op = 3'(i >> 1);
				t.fp_dbl = i[0];
				h = m[0] ? vword({vab[31:10], vec, vab[1:0]}) : {vab[31:16], vec, vab[7:0]};
				h = h & ~32'h3;
				re = m[0] ? vec[0] : rv;
				trap(t, h);
				prior = cps_exp;
				cps_exp = (cps_exp & ~CPS_POST_MSK) | (CPS_POST_VAL & CPS_POST_MSK);
				cps_exp[CPS_RE] = re;
				check("freeze", {31'h0, freeze}, 32'h1);
				rd(OFS_OPS, prior);
				rd(OFS_CPS, cps_exp);
				rd(OFS_STA, {15'h0, vec[7:3] == 5'h07, vec, 8'h0});
			end
		end
		$display("test traps done");
		r = $random(seed);
		bus(1'h1, OFS_PC0, r);
		bus(1'h1, OFS_CHC, 32'h0);
		pc_step <= 1'h1;
		pc_next <= ~r;
		chc_we <= 1'h1;
		chc_next <= '1;
		@(posedge clock);
		pc_step <= 1'h0;
		chc_we <= 1'h0;
		rd(OFS_PC0, r);
		rd(OFS_CHC, 32'h0);
		for (int c = 0; c < 8; c++) begin
			r = $random(seed);
			tgt = {27'h0, r[4:0]};
			p1 = r & 32'hffff_fffc;
			nf = 0;
			nc = 0;
			nl = 0;
			bus(1'h1, OFS_CPS, 32'h401);
			bus(1'h1, OFS_OPS, tgt);
			bus(1'h1, OFS_CHC, 32'(c));
			bus(1'h1, OFS_PC1, p1);
			bus(1'h1, OFS_PC0, p1 + 32'h4);
			fq.push_back(p1);
			fq.push_back(p1 + 32'h4);
			irq_pending <= c[0];
			ret(c[1], c[2]);
			check("btc_flush", 32'(nf), 32'(c[1]));
			check("chan_restart", 32'(nc), 32'(c == 1));
			check("lm_restart", 32'(nl), 32'(c == 5));
			check("freeze", {31'h0, freeze}, 32'h0);
			rd(OFS_CPS, tgt | {26'h0, c[0], 5'h0});
			irq_pending <= 1'h0;
		end
		pc_step <= 1'h1;
		pc_next <= r;
		chc_we <= 1'h1;
		chc_next <= '1;
		@(posedge clock);
		pc_step <= 1'h0;
		chc_we <= 1'h0;
		rd(OFS_PC0, r);
		rd(OFS_PC1, p1 + 32'h4);
		rd(OFS_PC2, p1);
		rd(OFS_CHC, 32'h7);
		$display("test returns done");
		complete_run;
	end
endmodule // its_seq_bench
bind its_seq its_seq_properties chk (.*);
`default_nettype wire
